// ===== blcp_config_protect.sv
// register bank, bus slave and protection supervision for the backlight driver
`timescale 1ns/1ps
// Function
// - output sense at lockout level for 10 us: drive input disconnect high, latch off
// - switch current over limit: stop switching until next switching cycle
// - hard limit reached 5 consecutive switching cycles: latch off
// - derate enabled and die above 140C: lower LED current amplitude
// - first settings bit 7 enables thermal derating, default zero
// - thermal shutdown above upper threshold, recover below lower threshold
// - bus address from strap: float 0x38, low 0x3A, middle 0x39
// - first settings bits 6:5 select dimming mode, default mixed
// - first settings bit 4 selects mixed transfer point, default 25%
// - first settings bit 3 selects mixed output frequency, default 200Hz
// - first settings bits 2:1 select spread modulation rate, default 1/150
// - first settings bit 0 selects spread jitter range, default 1/10
// - second settings bit 7 enables phase shifting, default zero
// - second settings bits 6:5 select short threshold, default 5V
// - second settings bits 4:3 select switching frequency, default 400kHz
// - second settings bits 2:0 select active strings, default all four
// - third register: short enable, chip disable, six fault flags
// - fault flags set on fault, held until read back or reset
// - protection pulls fault output low, release 750 us after recovery
module blcp_config_protect
  import blcp_pkg::*;
#(
  parameter int unsigned FAULT_RELEASE_CYCLES_P = FAULT_RELEASE_CYCLES,
  parameter logic [5:0]  IDENTITY_FIELD         = 6'h2a  // arbitrary value
)
(
  input  wire logic            ref_clk,
  input  wire logic            rst_n,
  input  wire logic            sw_clk,
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe_n,
  input  wire logic [1:0]      addr_strap,
  input  wire blcp_analog_t    analog_in,
  input  wire logic            cur_limit_in,
  input  wire logic            cur_hard_in,
  output blcp_dim_cfg_t        dim_cfg,
  output blcp_phase_cfg_t      phase_cfg,
  output logic [3:0]           string_enable,
  output logic                 short_protect_enable,
  output logic                 thermal_derate_active,
  output logic                 device_shutdown,
  output logic                 input_disconnect_drive,
  output logic                 fault_indicator_out,
  output logic                 switch_gate
);

  // ----------------------------------------------------------------
  // types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_INDEX, ST_WDATA, ST_ACK, ST_TX, ST_TXACK
  } blcp_state_t;

  localparam logic [15:0] FR_LAST = 16'(FAULT_RELEASE_CYCLES_P - 1);

  function automatic logic [3:0] string_decode(input logic [2:0] code);
    logic [3:0] en;
    en = 4'hf;
    case (code)
      3'h3:    en = 4'h7;
      3'h4:    en = 4'h3;
      3'h5:    en = 4'h1;
      default: en = 4'hf;  // reserved codes fall back to all strings
    endcase
    return en;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers, reference domain
  // ----------------------------------------------------------------
  logic [10:0]     rs1_reg;
  logic [10:0]     rs2_reg;
  logic [10:0]     rs3_reg;
  logic [10:0]     rstable_reg;
  logic            scl_s;
  logic            sda_s;
  logic            scl_q_reg;
  logic            sda_q_reg;
  blcp_analog_t    ana;
  logic [1:0]      strap_s;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rs1_reg     <= REF_SYNC_RST;
      rs2_reg     <= REF_SYNC_RST;
      rs3_reg     <= REF_SYNC_RST;
      rstable_reg <= REF_SYNC_RST;
      scl_q_reg   <= 1'b1;
      sda_q_reg   <= 1'b1;
    end
    else
    begin
      rs1_reg     <= {scl_in, sda_in, analog_in, addr_strap};
      rs2_reg     <= rs1_reg;
      rs3_reg     <= rs2_reg;
      // take a bit only when the last two stages agree
      rstable_reg <= (rs3_reg & ~(rs2_reg ^ rs3_reg)) | (rstable_reg & (rs2_reg ^ rs3_reg));
      scl_q_reg   <= scl_s;
      sda_q_reg   <= sda_s;
    end
  end

  assign scl_s   = rstable_reg[10];
  assign sda_s   = rstable_reg[9];
  assign ana     = rstable_reg[8:2];
  assign strap_s = rstable_reg[1:0];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  logic [2:0]      strap_cnt_reg;
  logic            addr_ready_reg;
  logic [6:0]      dev_addr_reg;

  // caught once after release; a strap moving later is ignored
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_cnt_reg  <= 3'h0;
      addr_ready_reg <= 1'b0;
      dev_addr_reg   <= ADDR_FLOAT;
    end
    else if (!addr_ready_reg)
    begin
      strap_cnt_reg <= strap_cnt_reg + 3'h1;
      if (strap_cnt_reg == STRAP_SETTLE_LAST)
      begin
        addr_ready_reg <= 1'b1;
        unique case (strap_s)
          STRAP_LOW: dev_addr_reg <= ADDR_LOW;
          STRAP_MID: dev_addr_reg <= ADDR_MID;
          default:   dev_addr_reg <= ADDR_FLOAT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  blcp_state_t     st_reg;
  blcp_state_t     after_reg;
  logic [3:0]      bit_cnt_reg;
  logic [7:0]      sr_reg;
  logic [7:0]      tx_sr_reg;
  logic [7:0]      idx_reg;
  logic            nack_reg;
  logic            sda_oe_n_reg;
  logic            wr_en_reg;
  logic [7:0]      wr_idx_reg;
  logic [7:0]      wr_data_reg;
  logic            rd_clr_reg;
  logic [7:0]      rd_data;
  logic            bus_start;
  logic            bus_stop;
  logic            scl_rise;
  logic            scl_fall;

  blcp_dim_cfg_t   dim_cfg_reg;
  blcp_phase_cfg_t phase_cfg_reg;
  logic [1:0]      prot_ctrl_reg;
  logic [5:0]      flags_reg;

  assign bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  assign bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
  assign scl_rise  = scl_s & ~scl_q_reg;
  assign scl_fall  = ~scl_s & scl_q_reg;

  always_comb
  begin
    rd_data = 8'h00;
    case (idx_reg)
      REG_DIM_CFG:   rd_data = dim_cfg_reg;
      REG_PHASE_CFG: rd_data = phase_cfg_reg;
      REG_PROT:      rd_data = {prot_ctrl_reg, flags_reg};
      REG_ID:        rd_data = {2'h0, IDENTITY_FIELD};
      default:       rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= ST_IDLE;
      after_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      sr_reg       <= 8'h00;
      tx_sr_reg    <= 8'h00;
      idx_reg      <= 8'h00;
      nack_reg     <= 1'b0;
      sda_oe_n_reg <= 1'b1;
      wr_en_reg    <= 1'b0;
      wr_idx_reg   <= 8'h00;
      wr_data_reg  <= 8'h00;
      rd_clr_reg   <= 1'b0;
    end
    else
    begin
      wr_en_reg  <= 1'b0;
      rd_clr_reg <= 1'b0;
      if (bus_start && addr_ready_reg)
      begin
        st_reg       <= ST_ADDR;
        bit_cnt_reg  <= 4'h0;
        sda_oe_n_reg <= 1'b1;
      end
      else if (bus_stop)
      begin
        st_reg       <= ST_IDLE;
        sda_oe_n_reg <= 1'b1;
      end
      else if (scl_rise)
      begin
        unique case (st_reg)
          ST_ADDR, ST_INDEX, ST_WDATA:
          begin
            sr_reg      <= {sr_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          ST_TX:    bit_cnt_reg <= bit_cnt_reg + 4'h1;
          ST_TXACK: nack_reg    <= sda_s;
          ST_IDLE, ST_ACK: ;
        endcase
      end
      else if (scl_fall)
      begin
        unique case (st_reg)
          ST_ADDR:
            if (bit_cnt_reg == BYTE_BITS)
            begin
              bit_cnt_reg <= 4'h0;
              if (sr_reg[7:1] == dev_addr_reg)
              begin
                sda_oe_n_reg <= 1'b0;
                after_reg    <= sr_reg[0] ? ST_TX : ST_INDEX;
                st_reg       <= ST_ACK;
              end
              else
                st_reg <= ST_IDLE;
            end
          ST_INDEX:
            if (bit_cnt_reg == BYTE_BITS)
            begin
              bit_cnt_reg  <= 4'h0;
              idx_reg      <= sr_reg;
              sda_oe_n_reg <= 1'b0;
              after_reg    <= ST_WDATA;
              st_reg       <= ST_ACK;
            end
          ST_WDATA:
            if (bit_cnt_reg == BYTE_BITS)
            begin
              bit_cnt_reg  <= 4'h0;
              wr_en_reg    <= 1'b1;
              wr_idx_reg   <= idx_reg;
              wr_data_reg  <= sr_reg;
              idx_reg      <= idx_reg + 8'h01;
              sda_oe_n_reg <= 1'b0;
              after_reg    <= ST_WDATA;
              st_reg       <= ST_ACK;
            end
          ST_ACK:
          begin
            st_reg      <= after_reg;
            bit_cnt_reg <= 4'h0;
            if (after_reg == ST_TX)
            begin
              tx_sr_reg    <= rd_data;
              sda_oe_n_reg <= rd_data[7];
              idx_reg      <= idx_reg + 8'h01;
              rd_clr_reg   <= (idx_reg == REG_PROT);
            end
            else
              sda_oe_n_reg <= 1'b1;
          end
          ST_TX:
            if (bit_cnt_reg == BYTE_BITS)
            begin
              sda_oe_n_reg <= 1'b1;
              st_reg       <= ST_TXACK;
            end
            else
            begin
              sda_oe_n_reg <= tx_sr_reg[6];
              tx_sr_reg    <= {tx_sr_reg[6:0], 1'b0};
            end
          ST_TXACK:
            if (nack_reg)
              st_reg <= ST_IDLE;
            else
            begin
              st_reg       <= ST_TX;
              bit_cnt_reg  <= 4'h0;
              tx_sr_reg    <= rd_data;
              sda_oe_n_reg <= rd_data[7];
              idx_reg      <= idx_reg + 8'h01;
              rd_clr_reg   <= (idx_reg == REG_PROT);
            end
          ST_IDLE: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  // writes to the identity and unmapped indices are dropped
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dim_cfg_reg   <= DIM_CFG_RST;
      phase_cfg_reg <= PHASE_CFG_RST;
      prot_ctrl_reg <= PROT_CTRL_RST;
    end
    else if (wr_en_reg)
    begin
      if (wr_idx_reg == REG_DIM_CFG)
        dim_cfg_reg <= wr_data_reg;
      if (wr_idx_reg == REG_PHASE_CFG)
        phase_cfg_reg <= wr_data_reg;
      if (wr_idx_reg == REG_PROT)
        prot_ctrl_reg <= wr_data_reg[PROT_CTRL_MSB:PROT_CTRL_LSB];
    end
  end

  // ----------------------------------------------------------------
  // switching domain: cycle limit and hard limit count
  // ----------------------------------------------------------------
  logic [1:0]      cs1_reg;
  logic [1:0]      cs2_reg;
  logic [1:0]      cs3_reg;
  logic [1:0]      cstable_reg;
  logic            off_s1_reg;
  logic            off_s2_reg;
  logic [2:0]      phase_reg;
  logic            gate_reg;
  logic            hard_seen_reg;
  logic [2:0]      hard_cnt_reg;
  logic            ocp_latch_reg;
  logic            period_end;
  logic            hard_hit;
  logic            device_shutdown_reg;

  assign period_end = (phase_reg == SW_PERIOD_LAST);
  assign hard_hit   = hard_seen_reg | cstable_reg[0];

  always_ff @(posedge sw_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs1_reg     <= SW_SYNC_RST;
      cs2_reg     <= SW_SYNC_RST;
      cs3_reg     <= SW_SYNC_RST;
      cstable_reg <= SW_SYNC_RST;
      off_s1_reg  <= 1'b1;
      off_s2_reg  <= 1'b1;
      phase_reg   <= 3'h0;
    end
    else
    begin
      cs1_reg     <= {cur_limit_in, cur_hard_in};
      cs2_reg     <= cs1_reg;
      cs3_reg     <= cs2_reg;
      cstable_reg <= (cs3_reg & ~(cs2_reg ^ cs3_reg)) | (cstable_reg & (cs2_reg ^ cs3_reg));
      off_s1_reg  <= device_shutdown_reg;
      off_s2_reg  <= off_s1_reg;
      phase_reg   <= phase_reg + 3'h1;
    end
  end

  // comparator delay costs four sync ticks of the period, the gate drops on the fifth; faster sense needs analog help
  always_ff @(posedge sw_clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_reg <= 1'b0;
    else if (off_s2_reg || ocp_latch_reg)
      gate_reg <= 1'b0;
    else if (period_end)
      gate_reg <= 1'b1;
    else if (cstable_reg[1])
      gate_reg <= 1'b0;
  end

  always_ff @(posedge sw_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hard_seen_reg <= 1'b0;
      hard_cnt_reg  <= 3'h0;
      ocp_latch_reg <= 1'b0;
    end
    else if (!ocp_latch_reg)
    begin
      if (period_end)
      begin
        hard_seen_reg <= 1'b0;
        if (!hard_hit)
          hard_cnt_reg <= 3'h0;
        else if (hard_cnt_reg == HARD_LIMIT_LAST)
          ocp_latch_reg <= 1'b1;
        else
          hard_cnt_reg <= hard_cnt_reg + 3'h1;
      end
      else if (cstable_reg[0])
        hard_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // protection supervision, reference domain
  // ----------------------------------------------------------------
  logic            ocp_s1_reg;
  logic            ocp_s2_reg;
  logic [6:0]      undervoltage_lockout_cnt_reg;
  logic            undervoltage_lockout_latch_reg;
  logic            thermal_sd_reg;
  logic            derate_reg;
  logic [3:0]      string_enable_reg;
  logic [15:0]     ff_cnt_reg;
  logic            ff_out_reg;
  logic            prot_active;
  logic [5:0]      flag_set;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ocp_s1_reg <= 1'b0;
      ocp_s2_reg <= 1'b0;
    end
    else
    begin
      ocp_s1_reg <= ocp_latch_reg;
      ocp_s2_reg <= ocp_s1_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      undervoltage_lockout_cnt_reg   <= 7'h00;
      undervoltage_lockout_latch_reg <= 1'b0;
    end
    else if (!undervoltage_lockout_latch_reg)
    begin
      if (!ana.undervoltage_lockout)
        undervoltage_lockout_cnt_reg <= 7'h00;
      else if (undervoltage_lockout_cnt_reg == UNDERVOLTAGE_LOCKOUT_LAST)
        undervoltage_lockout_latch_reg <= 1'b1;
      else
        undervoltage_lockout_cnt_reg <= undervoltage_lockout_cnt_reg + 7'h01;
    end
  end

  // hysteresis itself sits in the two analog comparators
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      thermal_sd_reg <= 1'b0;
    else if (ana.temp_high)
      thermal_sd_reg <= 1'b1;
    else if (ana.temp_low)
      thermal_sd_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      device_shutdown_reg <= 1'b1;
      derate_reg          <= 1'b0;
      string_enable_reg   <= 4'hf;
    end
    else
    begin
      device_shutdown_reg <= undervoltage_lockout_latch_reg | ocp_s2_reg | thermal_sd_reg
                             | prot_ctrl_reg[0];
      derate_reg          <= dim_cfg_reg.thermal_derate_enable & ana.temp_derate;
      string_enable_reg   <= string_decode(phase_cfg_reg.active_string_sel);
    end
  end

  assign flag_set = {ana.string_ground_short, thermal_sd_reg, undervoltage_lockout_latch_reg,
                     ocp_s2_reg, ana.source_short, ana.source_open};

  // a fault present in the read cycle stays set
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= FLAGS_RST;
    else
      flags_reg <= (flags_reg & ~{6{rd_clr_reg}}) | flag_set;
  end

  assign prot_active = |flag_set;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ff_cnt_reg <= FR_LAST;
      ff_out_reg <= 1'b1;
    end
    else if (prot_active)
    begin
      ff_cnt_reg <= 16'h0000;
      ff_out_reg <= 1'b0;
    end
    else if (ff_cnt_reg == FR_LAST)
      ff_out_reg <= 1'b1;
    else
      ff_cnt_reg <= ff_cnt_reg + 16'h0001;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign sda_out                = 1'b0;
  assign sda_oe_n               = sda_oe_n_reg;
  assign dim_cfg                = dim_cfg_reg;
  assign phase_cfg              = phase_cfg_reg;
  assign string_enable          = string_enable_reg;
  assign short_protect_enable   = prot_ctrl_reg[1];
  assign thermal_derate_active  = derate_reg;
  assign device_shutdown        = device_shutdown_reg;
  assign input_disconnect_drive = undervoltage_lockout_latch_reg;
  assign fault_indicator_out    = ff_out_reg;
  assign switch_gate            = gate_reg;

endmodule // blcp_config_protect

// ===== blcp_pkg.sv
// constants, field layouts and carrier types for the backlight config and protection block
package blcp_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_DIM_CFG   = 8'h00;
  localparam logic [7:0] REG_PHASE_CFG = 8'h01;
  localparam logic [7:0] REG_PROT      = 8'h02;
  localparam logic [7:0] REG_ID        = 8'h03;

  localparam logic [7:0] DIM_CFG_RST   = 8'h02;
  localparam logic [7:0] PHASE_CFG_RST = 8'h28;
  localparam logic [1:0] PROT_CTRL_RST = 2'h0;
  localparam logic [5:0] FLAGS_RST     = 6'h00;
  localparam int         PROT_CTRL_MSB = 7;
  localparam int         PROT_CTRL_LSB = 6;

  // ----------------------------------------------------------------
  // bus address from strap
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_FLOAT = 2'h0;
  localparam logic [1:0] STRAP_LOW   = 2'h1;
  localparam logic [1:0] STRAP_MID   = 2'h2;
  localparam logic [6:0] ADDR_FLOAT  = 7'h38;
  localparam logic [6:0] ADDR_MID    = 7'h39;
  localparam logic [6:0] ADDR_LOW    = 7'h3a;
  localparam logic [2:0] STRAP_SETTLE_LAST = 3'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS        = 100;
  localparam int         UNDERVOLTAGE_LOCKOUT_TIME_NS         = 10000;
  localparam int         UNDERVOLTAGE_LOCKOUT_CYCLES          = (UNDERVOLTAGE_LOCKOUT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] UNDERVOLTAGE_LOCKOUT_LAST            = 7'(UNDERVOLTAGE_LOCKOUT_CYCLES - 1);
  localparam int         FAULT_RELEASE_NS     = 750000;
  localparam int         FAULT_RELEASE_CYCLES =
    (FAULT_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] HARD_LIMIT_LAST      = 3'h4;
  localparam logic [2:0] SW_PERIOD_LAST       = 3'h7;
  localparam logic [3:0] BYTE_BITS            = 4'h8;

  // sync vector reset: scl and sda idle high
  localparam logic [10:0] REF_SYNC_RST = 11'h600;
  localparam logic [1:0]  SW_SYNC_RST  = 2'h0;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       thermal_derate_enable;
    logic       dim_select_hi;
    logic       dim_select_lo;
    logic       mixed_transfer_point_sel;
    logic       mixed_out_freq_sel;
    logic [1:0] spread_mod_rate_sel;
    logic       spread_jitter_range_sel;
  } blcp_dim_cfg_t;

  typedef struct packed {
    logic       phase_shift_enable;
    logic [1:0] short_threshold_sel;
    logic [1:0] switch_freq_sel;
    logic [2:0] active_string_sel;
  } blcp_phase_cfg_t;

  typedef struct packed {
    logic undervoltage_lockout;
    logic temp_derate;
    logic temp_high;
    logic temp_low;
    logic string_ground_short;
    logic source_short;
    logic source_open;
  } blcp_analog_t;

endpackage

// ===== blcp_props.sv
// concurrent checks on the config and protection block ports
`timescale 1ns/1ps
module blcp_props
  import blcp_pkg::*;
(
  input wire logic            ref_clk,
  input wire logic            rst_n,
  input wire blcp_analog_t    analog_in,
  input wire blcp_dim_cfg_t   dim_cfg,
  input wire blcp_phase_cfg_t phase_cfg,
  input wire logic [3:0]      string_enable,
  input wire logic            thermal_derate_active,
  input wire logic            device_shutdown,
  input wire logic            input_disconnect_drive,
  input wire logic            fault_indicator_out,
  input wire logic            switch_gate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [3:0] strs(input logic [2:0] c);
    return c == 3'h3 ? 4'h7 : c == 3'h4 ? 4'h3 : c == 3'h5 ? 4'h1 : 4'hf;
  endfunction
  sequence s_derate8;
    (dim_cfg.thermal_derate_enable && analog_in.temp_derate) [*8];
  endsequence
  sequence s_flt_low8;
    !fault_indicator_out [*8];
  endsequence
  AST_LATCH_SHUT: assert property (input_disconnect_drive |=> device_shutdown)
    else $error("disconnect without shutdown");
  AST_LATCH_HOLD: assert property (input_disconnect_drive |=> input_disconnect_drive)
    else $error("disconnect released");
  AST_DERATE_ON: assert property (s_derate8 |-> thermal_derate_active)
    else $error("derate missing");
  AST_DERATE_EN: assert property (thermal_derate_active |-> $past(dim_cfg[7]))
    else $error("derate while disabled");
  AST_STRINGS: assert property (string_enable == strs($past(phase_cfg[2:0])))
    else $error("string decode");
  AST_THERM: assert property ($rose(analog_in.temp_high) |-> ##[1:8] device_shutdown)
    else $error("no thermal shutdown");
  AST_FLT_LOW: assert property (input_disconnect_drive |=> !fault_indicator_out)
    else $error("fault output high");
  AST_FLT_HOLD: assert property ($fell(fault_indicator_out) |-> s_flt_low8)
    else $error("fault output short");
  AST_GATE_OFF: assert property (device_shutdown [*8] |-> !switch_gate)
    else $error("switching while shut");
endmodule // blcp_props

bind blcp_config_protect blcp_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .analog_in(analog_in), .dim_cfg(dim_cfg),
  .phase_cfg(phase_cfg), .string_enable(string_enable),
  .thermal_derate_active(thermal_derate_active), .device_shutdown(device_shutdown),
  .input_disconnect_drive(input_disconnect_drive),
  .fault_indicator_out(fault_indicator_out), .switch_gate(switch_gate));

// ===== blcp_host_model.sv
// bus controller model driving the serial clock and data pins
`timescale 1ns/1ps
module blcp_host_model (
  input  wire logic ref_clk,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  output logic      scl_in,
  output logic      sda_in
);
  logic sda_m = 1'h1;
  // pulled-up wire: low when either side pulls
  assign sda_in = sda_m & (sda_oe_n | sda_out);
  initial scl_in = 1'h1;
  task automatic q();
    repeat (12) @(negedge ref_clk);
  endtask
  task automatic start();
    sda_m = 1'h1;
    q();
    scl_in = 1'h1;
    q();
    sda_m = 1'h0;
    q();
    scl_in = 1'h0;
  endtask
  task automatic stop();
    q();
    sda_m = 1'h0;
    q();
    scl_in = 1'h1;
    q();
    sda_m = 1'h1;
    q();
  endtask
  // data moves only while the clock is low, never beside its edge
  task automatic bit_io(input logic b, output logic r);
    q();
    sda_m = b;
    q();
    scl_in = 1'h1;
    q();
    r = sda_in;
    q();
    scl_in = 1'h0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    logic t;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], t);
      r[i] = t;
    end
    bit_io(a, k);
  endtask
endmodule // blcp_host_model

// ===== test_blcp_config_protect.sv
// self-checking bench for the config and protection block
`timescale 1ns/1ps
module test_blcp_config_protect;
  import blcp_pkg::*;
  localparam logic [5:0] ID = 6'h15;  // arbitrary value
  logic            ref_clk, sw_clk, rst_n, cl, ch, so, oe_n, sda, scl;
  logic            ak, spe, tda, sd, dis, ff, gt;
  logic [1:0]      strap;
  logic [3:0]      se;
  logic [6:0]      dev;
  logic [7:0]      rd, v;
  blcp_analog_t    an;
  blcp_dim_cfg_t   dim;
  blcp_phase_cfg_t ph;
  int              n_mismatch = 0, tests_run = 0, seed = 85, k;
  int              mdl [4];
  logic [6:0]      adr [3] = '{7'h38, 7'h3a, 7'h39};
  blcp_config_protect #(.FAULT_RELEASE_CYCLES_P(20), .IDENTITY_FIELD(ID)) u_blcp_config_protect (
    .ref_clk(ref_clk), .rst_n(rst_n), .sw_clk(sw_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(so), .sda_oe_n(oe_n), .addr_strap(strap), .analog_in(an), .cur_limit_in(cl),
    .cur_hard_in(ch), .dim_cfg(dim), .phase_cfg(ph), .string_enable(se),
    .short_protect_enable(spe), .thermal_derate_active(tda), .device_shutdown(sd),
    .input_disconnect_drive(dis), .fault_indicator_out(ff), .switch_gate(gt));
  blcp_host_model u_host (.ref_clk(ref_clk), .sda_out(so), .sda_oe_n(oe_n), .scl_in(scl),
    .sda_in(sda));
  initial
  begin
    ref_clk = 1'h0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial
  begin
    sw_clk = 1'h0;
    #7;
    forever #16 sw_clk = ~sw_clk;
  end
  function automatic logic [3:0] strs(input logic [2:0] c);
    return c == 3'h3 ? 4'h7 : c == 3'h4 ? 4'h3 : c == 3'h5 ? 4'h1 : 4'hf;
  endfunction
  task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic rst(input logic [1:0] s);
    rst_n = 1'h0;
    strap = s;
    w(4);
    rst_n = 1'h1;
    w(12);
    mdl = '{8'h02, 8'h28, 8'h00, {2'h0, ID}};
  endtask
  task automatic probe(input logic [6:0] a, input logic e);
    u_host.start();
    u_host.xfer({a, 1'h0}, 1'h1, rd, ak);
    u_host.stop();
    chk("ack", ak, e);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    u_host.start();
    u_host.xfer({dev, 1'h0}, 1'h1, rd, ak);
    u_host.xfer(i, 1'h1, rd, ak);
    u_host.xfer(d, 1'h1, rd, ak);
    chk("wack", ak, 1'h0);
    u_host.stop();
    if (i < 2)
      mdl[i] = d;
    if (i == 2)
      mdl[2] = {d[7:6], mdl[2][5:0]};
  endtask
  task automatic rdx(input logic [7:0] i, input int n);
    u_host.start();
    u_host.xfer({dev, 1'h0}, 1'h1, rd, ak);
    u_host.xfer(i, 1'h1, rd, ak);
    u_host.start();
    u_host.xfer({dev, 1'h1}, 1'h1, rd, ak);
    for (int j = 0; j < n; j++)
    begin
      u_host.xfer(8'hff, j == n - 1, rd, ak);
      chk("read", rd, mdl[i + j]);
      if (i + j == 2)
        mdl[2] &= 8'hc0;
    end
    u_host.stop();
  endtask
  initial
  begin
    {an, cl, ch, rst_n, strap} = '0;
    for (int s = 0; s < 3; s++)
    begin
      rst(s[1:0]);
      dev = adr[s];
      probe(dev, 1'h0);
      probe(adr[(s + 1) % 3], 1'h1);
    end
    rdx(8'h0, 4);
    chk("ph", ph, mdl[1]);
    for (int c = 0; c < 8; c++)
    begin
      v = $random(seed);
      wr(8'h1, {v[7:3], c[2:0]});
      chk("str", se, strs(c[2:0]));
    end
    v = $random(seed);
    wr(8'h0, v);
    wr(8'h3, ~v);
    rdx(8'h0, 4);
    chk("dim", dim, v);
    wr(8'h2, 8'hc0);
    w(2);
    chk("dis", {so, spe, sd}, 3'h3);
    wr(8'h2, 8'h00);
    w(2);
    chk("dis", {spe, sd}, 2'h0);
    wr(8'h0, 8'h80);
    an.temp_derate = 1'h1;
    w(10);
    chk("derate", tda, 1'h1);
    an.temp_high = 1'h1;
    w(10);
    an.temp_high = 1'h0;
    w(10);
    chk("hot", {sd, ff}, 2'h2);
    an.temp_low = 1'h1;
    w(10);
    chk("cool", {sd, ff}, 2'h0);
    w(20);
    chk("ff", ff, 1'h1);
    mdl[2] = 8'h10;
    rdx(8'h2, 1);
    rdx(8'h2, 1);
    k = 0;
    cl = 1'h1;
    repeat (20)
    begin
      w(1);
      k += gt;
    end
    cl = 1'h0;
    w(10);
    chk("gate", {k < 16, gt}, 2'h3);
    ch = 1'h1;
    w(7);
    ch = 1'h0;
    w(10);
    chk("oc", sd, 1'h0);
    ch = 1'h1;
    w(30);
    chk("oc", {sd, gt}, 2'h2);
    mdl[2] = 8'h04;
    rdx(8'h2, 1);
    ch = 1'h0;
    rst(2'h2);
    an.undervoltage_lockout = 1'h1;
    w(95);
    an.undervoltage_lockout = 1'h0;
    w(10);
    chk("uv", dis, 1'h0);
    an.undervoltage_lockout = 1'h1;
    an[2:0] = 3'h7;
    w(110);
    chk("uv", {dis, sd}, 2'h3);
    mdl[2] = 8'h2b;
    rdx(8'h2, 1);
    print_verdict();
  end
  // watchdog well past the expected run length
  initial
  begin
    #6000000;
    n_mismatch++;
    print_verdict();
  end
endmodule // test_blcp_config_protect
